// ---- src/umf_cfg.svh ----
// Constants for the modem input, multi-function pin and reset block
`ifndef UMF_CFG_SVH
`define UMF_CFG_SVH
// APB byte offsets
`define UMF_OFF_MODEM_STATUS 12'h018
`define UMF_OFF_MODEM_CTRL 12'h010
`define UMF_OFF_AFR 12'h020
`define UMF_OFF_DLL 12'h000
`define UMF_OFF_DLM 12'h004
`define UMF_OFF_IER 12'h008
`define UMF_OFF_IST 12'h024
`define UMF_OFF_IMSK 12'h028
`define UMF_OFF_RXDMA 12'h02C
// Field positions
`define UMF_STAT_CARRIER 7
`define UMF_STAT_BELL 6
`define UMF_STAT_CARRIER_CHG 3
`define UMF_STAT_BELL_RISE 2
`define UMF_CTRL_GP_OUT 3
`define UMF_CTRL_LOOP 4
`define UMF_IER_MSI 3
`define UMF_AFR_SEL_LO 1
`define UMF_AFR_SEL_HI 2
// Reset values
`define UMF_CTRL_RST 8'h00
`define UMF_AFR_RST 8'h00
`define UMF_DIV_RST 16'h0001
`define UMF_IER_RST 8'h00
`define UMF_MSK_RST 2'h0
`endif

// ---- src/umf_pkg.sv ----
// Types for the modem input, multi-function pin and reset block
package umf_pkg;
   // Multi-function output selection
   typedef enum logic [1:0] {UMF_SEL_GP_OUT = 2'h0, UMF_SEL_BAUD = 2'h1, UMF_SEL_RXDMA = 2'h2,
      UMF_SEL_RSV = 2'h3} umf_sel_t;
   // APB request carrier
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } umf_apb_req_t;
   // APB answer carrier
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } umf_apb_rsp_t;
endpackage

// ---- src/umf_top.sv ----
// Modem carrier/bell inputs, multi-function pin, baud generator and master reset
//
// Contract
// R1: Status bit7 shows inverted carrier detect
// R2: Status bit3 flags carrier change since read
// R3: Carrier detect never touches the receiver
// R4: Carrier change raises enabled modem interrupt
// R5: Status bit6 shows inverted bell input
// R6: Status bit2 flags bell input rising
// R7: Bell bit falling raises enabled interrupt
// R8: Function bits 2:1 select pin source
// R9: Reset selects general output two
// R10: Control bit3 one drives output low
// R11: Master reset sets output two high
// R12: Loopback holds output two inactive
// R13: Baud clock is the 16x clock
// R14: Baud clock is crystal over divisor; a divisor of zero or one gives crystal over two here
// R15: Baud clock feeds receiver internally
// R16: DMA request asks receive FIFO drain
// R17: Master reset clears registers, keeps divisor
// R18: Master reset sets outputs to reset states
// R19: Reading status clears change bits
`timescale 1ns/1ps
`include "umf_cfg.svh"

module umf_top
#(
   parameter int DIV_W = 16,
   parameter int SYNC_DEPTH = 2
)
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic CARRIER_DETECT_N,
   input wire logic PHONE_BELL_DETECT_N,
   input wire logic RX_DMA_REQUEST_IN,
   input wire umf_pkg::umf_apb_req_t APB_REQ,
   output umf_pkg::umf_apb_rsp_t APB_RSP,
   output logic MULTI_FUNCTION_OUT,
   output logic RX_BAUD_CLK,
   output logic MODEM_IRQ,
   output logic IRQ
);
   import umf_pkg::*;

   // ************************************************************
   // Parameter checks
   // ************************************************************
   // The divisor is written one byte at a time, so only two bytes are served
   generate
      if (DIV_W != 16)
      begin : g_bad_div
         $error("umf_top: DIV_W must be 16");
      end
      // A single stage would let metastability reach the logic
      if (SYNC_DEPTH < 2)
      begin : g_bad_sync
         $error("umf_top: SYNC_DEPTH must be at least 2");
      end
   endgenerate

   // ************************************************************
   // Helpers
   // ************************************************************
   localparam int NPIN = 3;
   localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
   localparam logic [DIV_W-1:0] DIV_ZERO = '0;

   // Register offset match, used for every register select
   function automatic logic at_off(input logic [11:0] addr, input logic [11:0] off);
      at_off = (addr == off);
   endfunction

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   // Pin order: bit0 carrier, bit1 bell, bit2 DMA request
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync_q [0:SYNC_DEPTH-1];
   logic [NPIN-1:0] pin_s;
   logic car_prev_q;
   logic bell_prev_q;
   wire car_s;
   wire bell_s;
   wire dma_s;

   // Raw pins gathered for the first stage
   assign pin_raw = {RX_DMA_REQUEST_IN, PHONE_BELL_DETECT_N, CARRIER_DETECT_N};

   // First stage; preset high so idle active-low pins give no false edge
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         sync_q[0] <= '1;
      else
         sync_q[0] <= pin_raw;
   end

   // Later stages read only the stage before them
   generate
      for (genvar i = 1; i < SYNC_DEPTH; i++)
      begin : g_sync
         always_ff @(posedge MCLK or posedge RESET)
         begin
            if (RESET)
               sync_q[i] <= '1;
            else
               sync_q[i] <= sync_q[i-1];
         end
      end
   endgenerate

   // Only the last stage feeds the logic
   assign pin_s = sync_q[SYNC_DEPTH-1];
   assign car_s = pin_s[0];
   assign bell_s = pin_s[1];
   assign dma_s = pin_s[2];

   // Previous synchronised levels for change detection
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         car_prev_q <= 1'b1;
         bell_prev_q <= 1'b1;
      end
      else
      begin
         car_prev_q <= car_s;
         bell_prev_q <= bell_s;
      end
   end

   // ************************************************************
   // APB decode
   // ************************************************************
   logic [7:0] ctrl_q;
   logic [7:0] afr_q;
   logic [7:0] ier_q;
   logic [DIV_W-1:0] div_q;
   logic [1:0] chg_q;
   logic [1:0] ist_q;
   logic [1:0] imsk_q;
   logic [31:0] rdata_q;
   logic rdy_q;
   logic err_q;

   // Phase decode; an access only counts once ready is up
   wire setup = APB_REQ.psel && !APB_REQ.penable;
   wire access = APB_REQ.psel && APB_REQ.penable && rdy_q;
   wire wr = access && APB_REQ.pwrite;
   wire rd = access && !APB_REQ.pwrite;

   // Register selects
   wire a_stat = at_off(APB_REQ.paddr, `UMF_OFF_MODEM_STATUS);
   wire a_ctrl = at_off(APB_REQ.paddr, `UMF_OFF_MODEM_CTRL);
   wire a_afr = at_off(APB_REQ.paddr, `UMF_OFF_AFR);
   wire a_dll = at_off(APB_REQ.paddr, `UMF_OFF_DLL);
   wire a_dlm = at_off(APB_REQ.paddr, `UMF_OFF_DLM);
   wire a_ier = at_off(APB_REQ.paddr, `UMF_OFF_IER);
   wire a_ist = at_off(APB_REQ.paddr, `UMF_OFF_IST);
   wire a_imsk = at_off(APB_REQ.paddr, `UMF_OFF_IMSK);
   wire a_rxd = at_off(APB_REQ.paddr, `UMF_OFF_RXDMA);
   wire mapped = a_stat | a_ctrl | a_afr | a_dll | a_dlm | a_ier | a_ist | a_imsk | a_rxd;
   wire [7:0] wb = APB_REQ.pwdata[7:0];

   // No wait state: ready rises in the first access cycle
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         rdy_q <= 1'b0;
      else
         rdy_q <= setup;
   end

   // ************************************************************
   // Modem status
   // ************************************************************
   wire loop_on = ctrl_q[`UMF_CTRL_LOOP];
   // R1: inverted carrier
   wire stat_car = !car_s;
   // R5: inverted bell
   wire stat_bell = !bell_s;
   // R2: carrier change
   wire ev_car = car_s != car_prev_q;
   // R6: bell low-to-high
   wire ev_bell = !bell_prev_q && bell_s;
   // Other modem bits read zero; those inputs are handled elsewhere
   wire [7:0] stat_val = {stat_car, stat_bell, 2'b00, chg_q, 2'b00};
   wire [1:0] chg_d;
   // R19: read clears, but a same-cycle change wins so no edge is lost
   assign chg_d = ((rd && a_stat) ? 2'b00 : chg_q) | {ev_car, ev_bell};

   // R17: master reset clears the change flags
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         chg_q <= 2'b00;
      else
         chg_q <= chg_d;
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   // R17: control register cleared by master reset
   // R10: bit3 holds the general output request
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ctrl_q <= `UMF_CTRL_RST;
      else if (wr && a_ctrl)
         ctrl_q <= wb;
   end

   // R8: function select, reset picks general output two
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         afr_q <= `UMF_AFR_RST;
      else if (wr && a_afr)
         afr_q <= wb;
   end

   // R4: modem status interrupt enable
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ier_q <= `UMF_IER_RST;
      else if (wr && a_ier)
         ier_q <= wb;
   end

   // Interrupt mask, same layout as the sticky status
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         imsk_q <= `UMF_MSK_RST;
      else if (wr && a_imsk)
         imsk_q <= wb[1:0];
   end

   // R17: divisor latch survives master reset, so no reset branch
   always_ff @(posedge MCLK)
   begin
      if (wr && a_dll)
         div_q[7:0] <= wb;
      if (wr && a_dlm)
         div_q[15:8] <= wb;
   end

   // ************************************************************
   // Baud generator
   // ************************************************************
   logic [DIV_W-1:0] bcnt_q;
   logic baud_q;
   // Divisor zero behaves as one; until the latch is written the rate is unknown
   wire [DIV_W-1:0] div_eff = (div_q == DIV_ZERO) ? DIV_ONE : div_q;
   wire [DIV_W-1:0] bhalf = {1'b0, div_eff[DIV_W-1:1]};
   wire bwrap = bcnt_q >= div_eff - DIV_ONE;
   // A divisor of one cannot toggle at the full rate, so it halves instead
   wire div_unit = div_eff == DIV_ONE;

   // R14: clock divided by divisor, or by two for a divisor of zero or one
   // R13: 16x clock for the channel
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         bcnt_q <= DIV_ZERO;
         baud_q <= 1'b0;
      end
      else if (bwrap)
      begin
         bcnt_q <= DIV_ZERO;
         baud_q <= div_unit ? !baud_q : 1'b1;
      end
      else
      begin
         bcnt_q <= bcnt_q + DIV_ONE;
         if (bcnt_q + DIV_ONE >= bhalf && !div_unit)
            baud_q <= 1'b0;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   // R4: carrier change interrupt; R7: bell bit falls when the pin rises
   wire msi_req = ier_q[`UMF_IER_MSI] && (|chg_q);
   wire [1:0] ist_ev = {ev_bell, ev_car};
   // Sticky status: set wins over write-one clear
   wire [1:0] ist_d = (ist_q & ~((wr && a_ist) ? wb[1:0] : 2'b00)) | ist_ev;

   // Sticky status register
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ist_q <= 2'h0;
      else
         ist_q <= ist_d;
   end

   // ************************************************************
   // Read path
   // ************************************************************
   // Read data mux; unmapped offsets read zero
   wire [7:0] rd_mux = a_stat ? stat_val : a_ctrl ? ctrl_q : a_afr ? afr_q : a_ier ? ier_q :
      a_dll ? div_q[7:0] : a_dlm ? div_q[15:8] : a_ist ? {6'h00, ist_q} :
      a_imsk ? {6'h00, imsk_q} : a_rxd ? {7'h00, dma_s} : 8'h00;

   // Read data captured in setup and held until the next setup
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         rdata_q <= 32'h0000_0000;
      else if (setup)
         rdata_q <= {24'h00_0000, rd_mux};
   end

   // Error flag follows the same capture point as the data
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         err_q <= 1'b0;
      else if (setup)
         err_q <= !mapped;
   end

   // ************************************************************
   // Multi-function pin
   // ************************************************************
   umf_sel_t sel;
   logic pin_d;
   assign sel = umf_sel_t'(afr_q[`UMF_AFR_SEL_HI:`UMF_AFR_SEL_LO]);
   // R10: bit3 drives low; R12: loopback holds high; R11: reset high
   wire gp_pin = !(ctrl_q[`UMF_CTRL_GP_OUT] && !loop_on);

   // R8: source select; R9: reset value selects output two
   always_comb
   begin
      case (sel)
         UMF_SEL_GP_OUT: pin_d = gp_pin;
         UMF_SEL_BAUD: pin_d = baud_q;
         // R16: DMA request from the receive FIFO logic
         UMF_SEL_RXDMA: pin_d = dma_s;
         default: pin_d = gp_pin;
      endcase
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // R18: pin takes its inactive level under master reset
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         MULTI_FUNCTION_OUT <= 1'b1;
      else
         MULTI_FUNCTION_OUT <= pin_d;
   end

   // R15: baud clock routed as receiver clock
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         RX_BAUD_CLK <= 1'b0;
      else
         RX_BAUD_CLK <= baud_q;
   end

   // R18: modem interrupt low in reset
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         MODEM_IRQ <= 1'b0;
      else
         MODEM_IRQ <= msi_req;
   end

   // R18: summary interrupt uses next status, so a new event shows a cycle sooner
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         IRQ <= 1'b0;
      else
         IRQ <= |(ist_d & imsk_q);
   end

   // R3: carrier detect only reaches status, never the receiver path
   assign APB_RSP.pready = rdy_q;
   assign APB_RSP.pslverr = rdy_q && err_q;
   assign APB_RSP.prdata = rdata_q;
endmodule // umf_top

// ---- tb/umf_modem.sv ----
// Remote modem model driving the carrier and ring pins
`timescale 1ns/1ps
module umf_modem
#(
   parameter int LAG = 3
)
(
   input wire logic clk,
   input wire logic carrier_on,
   input wire logic ring_on,
   output logic carrier_detect_n,
   output logic phone_bell_detect_n
);
   logic [LAG-1:0] cd_q = '0;
   logic [LAG-1:0] bell_q = '0;
   // Pins follow the request after LAG cycles, so the block sees a slow partner
   always_ff @(posedge clk)
   begin
      cd_q <= {cd_q[LAG-2:0], carrier_on};
      bell_q <= {bell_q[LAG-2:0], ring_on};
   end
   // Both pins are active low
   assign carrier_detect_n = ~cd_q[LAG-1];
   assign phone_bell_detect_n = ~bell_q[LAG-1];
endmodule // umf_modem

// ---- tb/umf_chk_sva.sv ----
// Assertions on the modem input, multi-function pin and reset block
`timescale 1ns/1ps
`include "umf_cfg.svh"
module umf_chk
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic CARRIER_DETECT_N,
   input wire logic PHONE_BELL_DETECT_N,
   input wire umf_pkg::umf_apb_req_t APB_REQ,
   input wire umf_pkg::umf_apb_rsp_t APB_RSP,
   input wire logic MULTI_FUNCTION_OUT,
   input wire logic MODEM_IRQ,
   input wire logic IRQ
);
   import umf_pkg::*;
   logic [3:0] quiet_q;
   logic cd_q, bell_q, cd_f_q, bell_f_q;
   // Completed status read and pin movement
   wire rd = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && !APB_REQ.pwrite &&
      APB_REQ.paddr == `UMF_OFF_MODEM_STATUS;
   wire moved = cd_q != CARRIER_DETECT_N || bell_q != PHONE_BELL_DETECT_N;
   // Change flags; a pin change within a few cycles of a read is not modelled
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         {quiet_q, cd_q, bell_q, cd_f_q, bell_f_q} <= {4'h0, 4'hC};
      else
         {quiet_q, cd_q, bell_q, cd_f_q, bell_f_q} <= {moved ? 4'h0 : quiet_q + 4'(quiet_q != 4'hF),
            CARRIER_DETECT_N, PHONE_BELL_DETECT_N, (cd_q != CARRIER_DETECT_N) | (cd_f_q & !rd),
            (!bell_q & PHONE_BELL_DETECT_N) | (bell_f_q & !rd)};
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   sequence s_rd_quiet;
      rd && quiet_q > 4'h4;
   endsequence
   property p_cd_lvl; s_rd_quiet |-> APB_RSP.prdata[7] == !CARRIER_DETECT_N; endproperty
   property p_bell_lvl; s_rd_quiet |-> APB_RSP.prdata[6] == !PHONE_BELL_DETECT_N; endproperty
   property p_cd_chg; s_rd_quiet |-> APB_RSP.prdata[3] == cd_f_q; endproperty
   property p_bell_rise; s_rd_quiet |-> APB_RSP.prdata[2] == bell_f_q; endproperty
   property p_rd_clr; s_rd_quiet ##0 $past(rd, 2) |-> APB_RSP.prdata[3:2] == 2'h0; endproperty
   property p_irq_src; $rose(MODEM_IRQ) |-> $past(cd_f_q || bell_f_q); endproperty
   property p_rst_pin; $fell(RESET) |-> MULTI_FUNCTION_OUT; endproperty
   property p_rst_irq; $fell(RESET) |-> !IRQ && !MODEM_IRQ; endproperty
   a_cd_lvl: assert property (p_cd_lvl) else $error("carrier level bit wrong");
   a_bell_lvl: assert property (p_bell_lvl) else $error("bell level bit wrong");
   a_cd_chg: assert property (p_cd_chg) else $error("carrier change bit wrong");
   a_bell_rise: assert property (p_bell_rise) else $error("bell rise bit wrong");
   a_rd_clr: assert property (p_rd_clr) else $error("change bits not cleared by read");
   a_irq_src: assert property (p_irq_src) else $error("modem interrupt without event");
   a_rst_pin: assert property (p_rst_pin) else $error("pin not inactive after reset");
   a_rst_irq: assert property (p_rst_irq) else $error("interrupt set after reset");
endmodule // umf_chk

// ---- tb/testbench.sv ----
// Self-checking testbench for the modem input and multi-function pin block
`timescale 1ns/1ps
`include "umf_cfg.svh"
module testbench;
   import umf_pkg::*;
   logic MCLK = 0;
   logic RESET = 1;
   logic dma = 0;
   logic cd_on = 0;
   logic bell_on = 0;
   logic cd_n, bell_n, mfo, bclk, mirq, irq, err;
   logic [7:0] na, nb;
   umf_apb_req_t req = '0;
   umf_apb_rsp_t rsp;
   logic [31:0] rd;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2.5 MCLK = ~MCLK;
   // Run limit; a hang counts as a mismatch
   always @(posedge MCLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         close_out();
      end
   end
   umf_top dut (.MCLK(MCLK), .RESET(RESET), .CARRIER_DETECT_N(cd_n), .PHONE_BELL_DETECT_N(bell_n),
      .RX_DMA_REQUEST_IN(dma), .APB_REQ(req), .APB_RSP(rsp), .MULTI_FUNCTION_OUT(mfo), .RX_BAUD_CLK(bclk),
      .MODEM_IRQ(mirq), .IRQ(irq));
   umf_modem #(.LAG(4)) peer (.clk(MCLK), .carrier_on(cd_on), .ring_on(bell_on), .carrier_detect_n(cd_n),
      .phone_bell_detect_n(bell_n));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   // One APB transfer, left in access phase so a next one may follow at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
      @(posedge MCLK);
      req.penable <= 1'b1;
      do @(posedge MCLK); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
   endtask
   task automatic op(input logic w, input logic [11:0] a, input logic [7:0] d);
      apb(w, a, d);
      req <= '0;
      wt(2);
   endtask
   // Rising edges of the pin and of the receiver clock over 40 cycles
   task automatic cnt();
      logic pm, pb;
      pm = mfo;
      pb = bclk;
      na = 8'h00;
      nb = 8'h00;
      repeat (40)
      begin
         @(posedge MCLK);
         na = na + 8'(mfo & !pm);
         nb = nb + 8'(bclk & !pb);
         pm = mfo;
         pb = bclk;
      end
   endtask
   task automatic t_reset();
      chk(8'(mfo), 8'h01);
      chk({6'h00, irq, mirq}, 8'h00);
      op(1, `UMF_OFF_DLL, 8'h04);
      op(1, `UMF_OFF_DLM, 8'h00);
      op(0, `UMF_OFF_MODEM_CTRL, 8'h00);
      chk(rd[7:0], 8'h00);
      chk(8'(err), 8'h00);
   endtask
   task automatic t_carrier();
      op(1, `UMF_OFF_IER, 8'h08);
      cd_on <= 1'b1;
      wt(12);
      chk(8'(mirq), 8'h01);
      apb(0, `UMF_OFF_MODEM_STATUS, 8'h00);
      chk(rd[7:0] & 8'h88, 8'h88);
      apb(0, `UMF_OFF_MODEM_STATUS, 8'h00);
      chk(rd[7:0] & 8'h88, 8'h80);
      req <= '0;
      wt(3);
      chk(8'(mirq), 8'h00);
   endtask
   task automatic t_ring();
      bell_on <= 1'b1;
      wt(12);
      op(0, `UMF_OFF_MODEM_STATUS, 8'h00);
      chk(rd[7:0] & 8'h44, 8'h40);
      bell_on <= 1'b0;
      wt(12);
      chk(8'(mirq), 8'h01);
      op(0, `UMF_OFF_MODEM_STATUS, 8'h00);
      chk(rd[7:0] & 8'h44, 8'h04);
   endtask
   task automatic t_pin();
      op(1, `UMF_OFF_MODEM_CTRL, 8'h08);
      chk(8'(mfo), 8'h00);
      op(1, `UMF_OFF_MODEM_CTRL, 8'h18);
      chk(8'(mfo), 8'h01);
      op(1, `UMF_OFF_AFR, 8'h04);
      dma <= 1'b1;
      wt(5);
      chk(8'(mfo), 8'h01);
      dma <= 1'b0;
      op(1, `UMF_OFF_AFR, 8'h02);
      cnt();
      chk(na, 8'h0A);
      chk(nb, 8'h0A);
      op(1, `UMF_OFF_MODEM_CTRL, 8'h08);
      op(1, `UMF_OFF_AFR, 8'h06);
      chk(8'(mfo), 8'h00);
   endtask
   task automatic t_irq();
      op(1, `UMF_OFF_IST, 8'h03);
      op(1, `UMF_OFF_IMSK, 8'h01);
      chk(8'(irq), 8'h00);
      cd_on <= 1'b0;
      wt(12);
      chk(8'(irq), 8'h01);
      op(1, `UMF_OFF_IST, 8'h01);
      chk(8'(irq), 8'h00);
      op(1, `UMF_OFF_IMSK, 8'h00);
      cd_on <= 1'b1;
      wt(12);
      chk(8'(irq), 8'h00);
      op(0, 12'h030, 8'h00);
      chk(rd[7:0], 8'h00);
      chk(8'(err), 8'h01);
   endtask
   // Master reset in mid-run keeps the divisor
   task automatic t_hard_reset();
      RESET <= 1'b1;
      wt(2);
      chk({5'h00, mfo, irq, mirq}, 8'h04);
      RESET <= 1'b0;
      wt(1);
      op(0, `UMF_OFF_MODEM_CTRL, 8'h00);
      chk(rd[7:0], 8'h00);
      op(1, `UMF_OFF_AFR, 8'h02);
      cnt();
      chk(na, 8'h0A);
   endtask
   task automatic close_out();
      $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      wt(16);
      RESET <= 1'b0;
      wt(1);
      t_reset();
      t_carrier();
      t_ring();
      t_pin();
      t_irq();
      t_hard_reset();
      close_out();
   end
endmodule // testbench
bind umf_top umf_chk u_chk (.MCLK, .RESET, .CARRIER_DETECT_N, .PHONE_BELL_DETECT_N, .APB_REQ, .APB_RSP,
   .MULTI_FUNCTION_OUT, .MODEM_IRQ, .IRQ);
